// ### pkg/selh_regs.svh
// selh_regs.svh: register offsets, field positions, reset values and counts
// assumes: included by the package and the design, word-aligned avalon slave
`ifndef SELH_REGS_SVH
`define SELH_REGS_SVH
`define SELH_CTRL_OFS       8'h00
`define SELH_STAT_OFS       8'h04
`define SELH_CLKSEL_OFS     8'h08
`define SELH_CTRL_NOLH_BIT  0
`define SELH_CTRL_CME_BIT   1
`define SELH_CTRL_FORCED_CLOCK_MONITOR_ENABLE_BIT  2
`define SELH_CTRL_DLY_BIT   3
`define SELH_CTRL_PSEUDO_STOP_ENABLE_BIT  4
`define SELH_CTRL_LIMP_HOME_IRQ_ENABLE_BIT  5
`define SELH_CTRL_AUTO_BIT  6
`define SELH_CTRL_RESET     8'h02
`define SELH_STAT_LHA_BIT   0
`define SELH_STAT_LIMP_HOME_IRQ_FLAG_BIT  1
`define SELH_STAT_STOP_BIT  2
`define SELH_STAT_PSTOP_BIT 3
`define SELH_CS_BUS_CLOCK_PLL_SELECT_BIT    0
`define SELH_CS_MCS_BIT     1
`define SELH_CNT_WIDTH      13
`define SELH_MID_COUNT      13'h1000
`endif

// ### pkg/selh_pkg.sv
// selh_pkg.sv: types for the stop exit and limp-home controller
// assumes: selh_regs.svh sits on the include path
package selh_pkg;
`include "selh_regs.svh"
   typedef enum logic [2:0] {
      SELH_RUN, SELH_STOP, SELH_EXIT_DLY, SELH_LIMP
   } selh_state_e;
   // wake-up sources, each a raw pin level
   typedef struct packed {
      logic ext_irq;
      logic nonmaskable_ext_irq;
      logic key_port_j;
      logic key_port_h;
      logic can_wake;
   } selh_wake_s;
   // clock steering outputs
   typedef struct packed {
      logic clk_from_vco;
      logic vco_restart;
      logic osc_low_amp;
      logic bus_clock_pll_select;
      logic module_clock_select;
      logic pll_ramp;
   } selh_clk_s;
endpackage

// ### logic/selh_ctrl.sv
// selh_ctrl.sv: stop / pseudo-stop exit and limp-home control with avalon slave
// assumes: clk 40 MHz, async active-high reset; slow_tick marks slow-domain clock
// edges; monitor and wake inputs are asynchronous pins.

// What this block does
// - limp-home off, monitor on: stop raises monitor failure reset.
// - limp-home on: monitor enables masked at stop entry, no failure.
// - stop exit with limp-home on and delay or no clock enters limp-home.
// - with delay, count 4096 on VCO; good clock ends limp-home.
// - no clock at 4096: leave stop in limp-home, status and irq set.
// - in limp-home poll the monitor at each mid-count, every 8192.
// - clock found: leave limp-home, clear status, set irq flag, gate by enable.
// - delay cleared: stop released at once, run in limp-home meanwhile.
// - leaving limp-home restores saved bus and module clock selects.
// - auto and pll select saved set: ramp system clock on relock.
// - square wave clock and no delay: exit at once, no limp flag.
// - pseudo-stop enable makes stop keep oscillator at low amplitude.
// - reset, irq lines, key wake-ups or can wake end stop.
// - pseudo-stop exit with delay: limp-home, vco counter, selects forced.
// - after 4096 use oscillator, else stay on vco with flags set.
// - pseudo-stop exit without delay completes at once.
// - pseudo-stop recovery on limp clock restarts the vco.
// - delay bit gives 4096 count delay; slow divider scales it.
module selh_ctrl (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                reset,
   // avalon-mm slave
   input  wire logic [7:0]          avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [31:0]         avs_writedata,
   output logic      [31:0]         avs_readdata,
   output logic                     avs_waitrequest,
   // core side
   input  wire logic                stop_exec,
   input  wire logic                slow_tick,
   // pins from outside
   input  wire logic                clock_present_raw,
   input  wire selh_pkg::selh_wake_s wake_raw,
   // results
   output selh_pkg::selh_clk_s      clk_ctrl,
   output logic                     core_halted,
   output logic                     monitor_fail_reset,
   output logic                     limp_home_irq
);
   import selh_pkg::*;

   // control word as written by software
   logic [7:0]                 ctrl_q;        // limp, monitor, delay, pseudo, irq, auto

   // clock selects and the copies saved when a wake-up starts
   logic                       bus_clock_pll_select_q;        // bus clock taken from the pll
   logic                       mcs_q;         // module clock select
   logic                       bus_clock_pll_select_sv_q;     // bus select before the loss
   logic                       mcs_sv_q;      // module select before the loss
   logic                       auto_sv_q;     // auto bandwidth before the loss

   // limp-home status
   logic                       lha_q;         // running on the limp clock
   logic                       limp_home_irq_flag_q;        // limp status has changed
   logic                       pstop_q;       // the current stop is a pseudo-stop

   // sequencer and its timebase
   selh_state_e                st_q;
   logic [`SELH_CNT_WIDTH-1:0] cnt_q;         // free-running slow-domain count

   // bus handshake
   logic                       wait_q;        // request taken, answer stands now
   logic                       waitreq_q;     // registered waitrequest, high when idle
   logic [31:0]                rdata_q;       // read word for the pending address

   // two-stage pin synchronisers
   logic [1:0]                 mon_s_q;       // clock monitor level
   selh_wake_s                 wk1_q;         // wake pins, first stage
   selh_wake_s                 wk2_q;         // wake pins, second stage

   // registered outputs
   selh_clk_s                  clk_ctrl_q;
   logic                       fail_q;
   logic                       irq_q;
   logic                       halt_q;

   // address match for the register decode, shared by every write strobe
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
      reg_hit = (addr == ofs);
   endfunction

   // named control bits
   // these read the stored control word, so a write during stop only takes
   // effect on the decisions that follow it
   wire nolh  = ctrl_q[`SELH_CTRL_NOLH_BIT];
   wire clock_monitor_enable   = ctrl_q[`SELH_CTRL_CME_BIT];
   wire forced_clock_monitor_enable  = ctrl_q[`SELH_CTRL_FORCED_CLOCK_MONITOR_ENABLE_BIT];
   wire dly   = ctrl_q[`SELH_CTRL_DLY_BIT];
   wire pseudo_stop_enable  = ctrl_q[`SELH_CTRL_PSEUDO_STOP_ENABLE_BIT];
   wire limp_home_irq_enable  = ctrl_q[`SELH_CTRL_LIMP_HOME_IRQ_ENABLE_BIT];
   wire autob = ctrl_q[`SELH_CTRL_AUTO_BIT];
   wire clock_ok = mon_s_q[1];
   wire wake_any = |wk2_q;
   // mid-count strobe of the free-running counter, one per 8192 ticks
   wire mid_strobe = slow_tick && (cnt_q == `SELH_MID_COUNT - 13'h0001);
   wire mon_on = clock_monitor_enable | forced_clock_monitor_enable;

   // bus decode; a request is taken on one edge and completes on the next,
   // while waitrequest stands low, so a write lands only at that second edge
   // and the master may release its request right after it
   wire bus_req   = (avs_read | avs_write) & ~wait_q;
   wire bus_done  = avs_write & wait_q;
   wire wr_ctrl   = bus_done & reg_hit(avs_address, `SELH_CTRL_OFS);
   wire wr_stat   = bus_done & reg_hit(avs_address, `SELH_STAT_OFS);
   wire wr_cs     = bus_done & reg_hit(avs_address, `SELH_CLKSEL_OFS);
   wire clr_limp_home_irq_flag  = wr_stat & avs_writedata[`SELH_STAT_LIMP_HOME_IRQ_FLAG_BIT];

   // state transition events
   // a stop with limp-home disabled and a monitor enabled never halts: the
   // monitor would see the stopped oscillator as a lost clock, so the block
   // reports the failure at once instead of entering stop
   // with limp-home allowed the monitor enables are simply not looked at on
   // entry, which is the masking that keeps stop from raising a failure
   wire go_stop   = (st_q == SELH_RUN) & stop_exec & ~(nolh & mon_on) & ~lha_q;
   wire stop_fail = stop_exec & nolh & mon_on & (st_q == SELH_RUN);
   wire waking    = (st_q == SELH_STOP) & wake_any;
   // limp-home on exit only when limp-home is allowed; pseudo-stop uses the same monitor level
   wire limp_exit = ~nolh & (dly | ~clock_ok);
   wire dly_done  = (st_q == SELH_EXIT_DLY) & mid_strobe;
   wire poll_ok   = (st_q == SELH_LIMP) & mid_strobe & clock_ok;
   wire enter_lh  = (dly_done & ~clock_ok) | (waking & ~dly & limp_exit);
   wire leave_lh  = poll_ok | (dly_done & clock_ok);
   wire lh_change = (enter_lh & ~lha_q) | (poll_ok & lha_q);
   wire lh_force  = (st_q == SELH_EXIT_DLY) | (st_q == SELH_LIMP);

   // pin synchronisers
   // the monitor level and every wake pin are asynchronous; only the second
   // stage is read by logic, so a metastable first stage never fans out
   // the wake sources are or-ed after the second stage, so any one of them
   // ends stop on its own
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mon_s_q <= 2'h0;
         wk1_q   <= '0;
         wk2_q   <= '0;
      end else begin
         mon_s_q <= {mon_s_q[0], clock_present_raw};
         wk1_q   <= wake_raw;
         wk2_q   <= wk1_q;
      end
   end

   // free-running counter advanced on slow-domain ticks
   // clearing it on a delayed wake makes the first mid-count strobe come a
   // full 4096 ticks later; otherwise it keeps running so the limp-home poll
   // lands once per wrap of 8192 ticks
   // the tick rate sets the real delay, so a slower divider lengthens it
   always_ff @(posedge clk or posedge reset) begin
      if (reset)
         cnt_q <= '0;
      else if (waking & dly)
         cnt_q <= '0;
      else if (slow_tick)
         cnt_q <= cnt_q + 13'h0001;
   end

   // exit sequencer
   // run: waits for a stop instruction that is allowed to halt
   // stop: waits for any synchronised wake source
   // exit delay: core still halted, counter on the vco until mid-count
   // limp: core runs on the vco, monitor polled at each mid-count
   // the delay path ends in run on a good clock or with limp-home disabled, and in limp otherwise; the
   // fast path goes straight to limp or run from the monitor level
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_q    <= SELH_RUN;
         pstop_q <= 1'b0;
      end else begin
         unique case (st_q)
            SELH_RUN: begin
               if (go_stop) begin
                  st_q    <= SELH_STOP;
                  pstop_q <= pseudo_stop_enable;
               end
            end
            SELH_STOP: begin
               if (waking) begin
                  if (dly & ~nolh)
                     st_q <= SELH_EXIT_DLY;
                  else if (dly)
                     st_q <= SELH_EXIT_DLY;
                  else if (limp_exit)
                     st_q <= SELH_LIMP;
                  else
                     st_q <= SELH_RUN;
               end
            end
            SELH_EXIT_DLY: begin
               if (dly_done)
                  st_q <= (clock_ok | nolh) ? SELH_RUN : SELH_LIMP;
            end
            SELH_LIMP: begin
               if (poll_ok)
                  st_q <= SELH_RUN;
            end
         endcase
      end
   end

   // limp-home status and interrupt flag; a new event beats a clear
   // the irq flag marks every change of the status flag, entry and exit
   // alike, and stays until software writes a one to it
   // a clear in the same cycle as a change is lost on purpose, so software
   // never misses a transition
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lha_q  <= 1'b0;
         limp_home_irq_flag_q <= 1'b0;
      end else begin
         if (enter_lh)
            lha_q <= 1'b1;
         else if (leave_lh)
            lha_q <= 1'b0;
         if (lh_change)
            limp_home_irq_flag_q <= 1'b1;
         else if (clr_limp_home_irq_flag)
            limp_home_irq_flag_q <= 1'b0;
      end
   end

   // control and clock select registers, saved across limp-home
   // the selects are copied at wake-up, before limp-home forces them, and
   // put back when limp-home ends
   // a bus select written while the clock is forced goes to the saved copy
   // too, so software can keep the pll off for the return of the clock
   // a write on the exit edge wins over the restore
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_q    <= `SELH_CTRL_RESET;
         bus_clock_pll_select_q    <= 1'b0;
         mcs_q     <= 1'b0;
         bus_clock_pll_select_sv_q <= 1'b0;
         mcs_sv_q  <= 1'b0;
         auto_sv_q <= 1'b0;
      end else begin
         if (wr_ctrl)
            ctrl_q <= avs_writedata[7:0];
         if (waking) begin
            bus_clock_pll_select_sv_q <= bus_clock_pll_select_q;
            mcs_sv_q  <= mcs_q;
            auto_sv_q <= autob;
         end
         if (wr_cs) begin
            bus_clock_pll_select_q <= avs_writedata[`SELH_CS_BUS_CLOCK_PLL_SELECT_BIT];
            mcs_q  <= avs_writedata[`SELH_CS_MCS_BIT];
            if (lh_force)
               bus_clock_pll_select_sv_q <= avs_writedata[`SELH_CS_BUS_CLOCK_PLL_SELECT_BIT];
         end else if (leave_lh & lha_q) begin
            bus_clock_pll_select_q <= bus_clock_pll_select_sv_q;
            mcs_q  <= mcs_sv_q;
         end
      end
   end

   // clock steering: limp forces vco, bus select high and module select low
   // the vco restart pulse only matters after a pseudo-stop, where the vco
   // was halted and comes back fast before it settles
   // the pll ramp pulse follows a limp exit when the saved settings had auto
   // bandwidth on and the pll driving the system clock
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         clk_ctrl_q <= '0;
      end else begin
         clk_ctrl_q.clk_from_vco         <= lh_force & ~nolh;
         clk_ctrl_q.vco_restart          <= waking & pstop_q & limp_exit;
         clk_ctrl_q.osc_low_amp          <= (st_q == SELH_STOP) & pstop_q;
         clk_ctrl_q.bus_clock_pll_select <= (lh_force & ~nolh) | bus_clock_pll_select_q;
         clk_ctrl_q.module_clock_select  <= ~(lh_force & ~nolh) & mcs_q;
         clk_ctrl_q.pll_ramp             <= leave_lh & lha_q & auto_sv_q & bus_clock_pll_select_sv_q;
      end
   end

   // core halt, monitor failure reset and interrupt request
   // the halt rises on the stop edge itself and stays through the delay;
   // the interrupt line follows the flag gated by its enable
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         halt_q <= 1'b0;
         fail_q <= 1'b0;
         irq_q  <= 1'b0;
      end else begin
         halt_q <= (st_q == SELH_STOP) | (st_q == SELH_EXIT_DLY) | go_stop;
         fail_q <= stop_fail;
         irq_q  <= limp_home_irq_flag_q & limp_home_irq_enable;
      end
   end

   // avalon response: one wait cycle, unmapped reads return zero
   // waitrequest is its own flop, high at rest, low for the one cycle in
   // which the answer stands; the read word is loaded on the taking edge
   // so it is settled when the master samples it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wait_q    <= 1'b0;
         waitreq_q <= 1'b1;
         rdata_q   <= '0;
      end else begin
         wait_q    <= bus_req;
         waitreq_q <= ~bus_req;
         unique case (avs_address)
            `SELH_CTRL_OFS:   rdata_q <= {24'h000000, ctrl_q};
            `SELH_STAT_OFS:   rdata_q <= {28'h0000000, pstop_q, halt_q, limp_home_irq_flag_q, lha_q};
            `SELH_CLKSEL_OFS: rdata_q <= {30'h00000000, mcs_q, bus_clock_pll_select_q};
            default:          rdata_q <= 32'h00000000;
         endcase
      end
   end

   // monitor enables read back as stored, in limp-home and at stop entry alike
   assign avs_readdata       = rdata_q;
   // every output comes straight from a flop
   assign avs_waitrequest    = waitreq_q;
   assign clk_ctrl           = clk_ctrl_q;
   assign core_halted        = halt_q;
   assign monitor_fail_reset = fail_q;
   assign limp_home_irq      = irq_q;
endmodule

// ### tb/selh_osc_model.sv
// selh_osc_model.sv: external crystal or clock source with its monitor level
// assumes: run is driven by the bench; start-up counted in core clocks
module selh_osc_model #(
   parameter int START_CYCLES = 16
) (
   input  wire logic clk,
   input  wire logic run,
   output logic      clock_present_raw
);
   timeunit 1ns;
   timeprecision 1ps;
   int age_q;
   // a crystal needs start-up time before the monitor reports it good
   always_ff @(posedge clk) begin
      if (!run) age_q <= 0;
      else if (age_q < START_CYCLES) age_q <= age_q + 1;
   end
   assign clock_present_raw = run && (age_q >= START_CYCLES);
endmodule

// ### tb/selh_ctrl_properties.sv
// selh_ctrl_properties.sv: port assertions for the stop exit controller
// assumes: bound to selh_ctrl; one clock, async active-high reset
module selh_ctrl_properties
   import selh_pkg::*;
(
   // clock and reset
   input wire logic                clk,
   input wire logic                reset,
   // bus and core side
   input wire logic                avs_read,
   input wire logic                avs_write,
   input wire logic                avs_waitrequest,
   input wire logic                stop_exec,
   // results
   input wire selh_pkg::selh_clk_s clk_ctrl,
   input wire logic                core_halted,
   input wire logic                monitor_fail_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // one wait cycle, then a single-cycle answer
   bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered next cycle");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   // failure reset comes from stop and replaces the halt
   fail_pulse_a: assert property (monitor_fail_reset |=> !monitor_fail_reset && !core_halted)
      else $error("failure reset not a lone pulse");
   fail_cause_a: assert property (monitor_fail_reset |-> $past(stop_exec) || $past(stop_exec, 2))
      else $error("failure reset without stop");
   halt_no_fail_a: assert property (core_halted |-> !monitor_fail_reset)
      else $error("failure raised while halted");
   halt_cause_a: assert property ($rose(core_halted) |-> $past(stop_exec) || $past(stop_exec, 2))
      else $error("halt without stop");
   // clock steering pulses and forced selects
   vco_pulse_a: assert property (clk_ctrl.vco_restart |=> !clk_ctrl.vco_restart)
      else $error("vco restart longer than a pulse");
   ramp_pulse_a: assert property (clk_ctrl.pll_ramp |=> !clk_ctrl.pll_ramp)
      else $error("ramp longer than a pulse");
   forced_sel_a: assert property (clk_ctrl.clk_from_vco |->
      clk_ctrl.bus_clock_pll_select && !clk_ctrl.module_clock_select)
      else $error("selects not forced on vco");
   cover property (monitor_fail_reset);
   cover property ($fell(core_halted));
   cover property ($fell(clk_ctrl.clk_from_vco));
endmodule

// ### tb/selh_ctrl_test.sv
// selh_ctrl_test.sv: self-checking bench for the stop exit controller
// assumes: slow_tick high every cycle, so one tick is one core clock
module selh_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   import selh_pkg::*;
   logic        clk, reset, avs_read, avs_write, stop_exec, slow_tick, osc_run, lo, vco;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic        avs_waitrequest, clock_present_raw, core_halted, monitor_fail_reset;
   logic        limp_home_irq, hit;
   selh_wake_s  wake_raw;
   selh_clk_s   clk_ctrl;
   int          err_count = 0, comparisons = 0, cyc = 0, n;
   selh_ctrl selh_ctrl_i (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .stop_exec, .slow_tick, .clock_present_raw, .wake_raw,
      .clk_ctrl, .core_halted, .monitor_fail_reset, .limp_home_irq);
   selh_osc_model selh_osc_model_i (.clk, .run(osc_run), .clock_present_raw);
   // clock and hang guard
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 70000) begin
         err_count++;
         summarize();
      end
   end
   task summarize;
      $display("checks %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task ck(string nm, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one bus transfer, held until waitrequest is seen low
   task bus(logic w, logic [7:0] a, logic [31:0] d);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 0;
      avs_read <= 0;
      @(posedge clk);
   endtask
   // stop with a control word, wake by one source, count cycles to exit
   task stp(logic [31:0] ctl, int src);
      bus(1, 8'h00, ctl);
      stop_exec <= 1;
      @(posedge clk);
      stop_exec <= 0;
      repeat (4) @(negedge clk);
      ck("halted", 1, core_halted);
      lo = clk_ctrl.osc_low_amp;
      @(posedge clk);
      wake_raw <= selh_wake_s'(5'h01 << src);
      n = 0;
      do begin
         @(negedge clk);
         n++;
         if (n == 100) vco = clk_ctrl.clk_from_vco;
      end while (core_halted !== 1'b0 && n < 9000);
      @(posedge clk);
      wake_raw <= '0;
   endtask
   // wait for the poll to drop limp-home once the oscillator is back
   task unlimp;
      osc_run <= 1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (clk_ctrl.clk_from_vco !== 1'b0 && n < 9000);
      ck("poll", 1, n <= 8230);
      @(posedge clk);
   endtask
   task t_fail;
      bus(1, 8'h00, 32'h03);
      stop_exec <= 1;
      @(posedge clk);
      stop_exec <= 0;
      hit = 0;
      repeat (4) begin
         @(negedge clk);
         hit |= monitor_fail_reset;
      end
      ck("fail", 1, hit);
      @(posedge clk);
   endtask
   task t_noclk;
      bus(1, 8'h08, 32'h01);
      osc_run <= 0;
      stp(32'h28, 0);
      ck("dly", 1, n >= 4096 && n < 4112);
      bus(0, 8'h04, 0);
      ck("limp", 32'h03, rd[1:0]);
      ck("irq", 1, limp_home_irq);
      bus(1, 8'h04, 32'h02);
      bus(1, 8'h08, 32'h00);
      unlimp();
      bus(0, 8'h04, 0);
      ck("back", 32'h02, rd[1:0]);
      bus(0, 8'h08, 0);
      ck("restore", 0, rd[1:0]);
   endtask
   initial begin
      {reset, avs_read, avs_write, stop_exec, avs_address, avs_writedata} = '1;
      {avs_read, avs_write, stop_exec, avs_address, avs_writedata} = '0;
      {slow_tick, osc_run, wake_raw} = '1;
      wake_raw = '0;
      repeat (6) @(posedge clk);
      reset <= 0;
      @(posedge clk);
      bus(0, 8'h00, 0);
      ck("ctrl_rst", 32'h02, rd);
      bus(1, 8'h0C, 32'hFF);
      bus(0, 8'h0C, 0);
      ck("unmapped", 0, rd);
      t_fail();
      for (int s = 0; s < 5; s++) begin
         stp(32'h0A, s);
         ck("dly", 1, n >= 4096 && n < 4112);
      end
      bus(0, 8'h04, 0);
      ck("good", 0, rd[1:0]);
      t_noclk();
      stp(32'h02, 1);
      ck("fast", 1, n < 12);
      bus(0, 8'h04, 0);
      ck("noflag", 0, rd[0]);
      osc_run <= 0;
      stp(32'h02, 2);
      ck("fast_limp", 1, n < 12);
      ck("on_vco", 1, clk_ctrl.clk_from_vco);
      unlimp();
      stp(32'h1A, 3);
      ck("low_amp", 1, lo);
      ck("vco_dly", 1, vco);
      ck("osc", 0, clk_ctrl.clk_from_vco);
      stp(32'h12, 4);
      ck("pfast", 1, n < 12);
      summarize();
   end
endmodule
bind selh_ctrl selh_ctrl_properties selh_ctrl_properties_i (.clk, .reset, .avs_read, .avs_write,
   .avs_waitrequest, .stop_exec, .clk_ctrl, .core_halted, .monitor_fail_reset);
